// *** src/sdcmd_regs.svh ***
`ifndef SDCMD_REGS_SVH
`define SDCMD_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SDCMD_CLK_NS 50
`define SDCMD_TRP_NS 20
`define SDCMD_TRP_CYC ((`SDCMD_TRP_NS + `SDCMD_CLK_NS - 1) / `SDCMD_CLK_NS)
`define SDCMD_TREFI_NS 15625
`define SDCMD_TREFI_CYC (`SDCMD_TREFI_NS / `SDCMD_CLK_NS)

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SDCMD_AP_BIT 10
`define SDCMD_MR_BL_HI 2
`define SDCMD_MR_BT 3
`define SDCMD_MR_CL_HI 6
`define SDCMD_MR_CL_LO 4
`define SDCMD_MR_WB 9
`define SDCMD_EMR_PARTIAL_ARRAY_SELF_REFRESH_HI 2
`define SDCMD_EMR_DS_HI 6
`define SDCMD_EMR_DS_LO 5
`define SDCMD_SEL_MODE 2'h0
`define SDCMD_SEL_EXT 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDCMD_MODE_RST 12'h030
`define SDCMD_PARTIAL_ARRAY_SELF_REFRESH_RST 3'h0

`endif

// *** src/sdcmd_pkg.sv ***
package sdcmd_pkg;

    typedef enum logic [2:0] {
        CMD_MRS = 3'b000,
        CMD_REF = 3'b001,
        CMD_PRE = 3'b010,
        CMD_ACT = 3'b011,
        CMD_WR = 3'b100,
        CMD_RD = 3'b101,
        CMD_BST = 3'b110,
        CMD_NOP = 3'b111
    } sdcmd_cmd_type;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_SELF = 2'b01,
        PWR_DEEP = 2'b10
    } sdcmd_pwr_type;

    typedef enum logic [1:0] {
        DRV_FULL = 2'b00,
        DRV_HALF = 2'b01,
        DRV_QUARTER = 2'b10
    } sdcmd_drive_type;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic [1:0] ba;
        logic [11:0] addr;
    } sdcmd_pins_type;

    typedef struct packed {
        logic [11:0] mode;
        logic [2:0] partial_array_self_refresh;
        sdcmd_drive_type drv;
        sdcmd_pwr_type pwr;
        logic [3:0] open;
        logic [3:0][11:0] row;
        logic [3:0][3:0] row_precharge_time;
        logic bst_act;
        logic bst_rd;
        logic bst_ap;
        logic [1:0] bst_bank;
        logic [7:0] bst_col;
        logic [2:0] bst_idx;
        logic [2:0][16:0] rpipe;
        logic [1:0][1:0] mpipe;
        logic [11:0] rcnt;
        logic [10:0] div;
        logic tick;
        logic hot;
    } sdcmd_state_type;

endpackage

// *** src/sdcmd_core.sv ***
`timescale 1ns/1ps
`include "sdcmd_regs.svh"

module sdcmd_core #(
    parameter int TREFI_CYC = `SDCMD_TREFI_CYC
) (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire sdcmd_pkg::sdcmd_pins_type CMD_I,
    input wire logic LOWER_BYTE_MASK_I,
    input wire logic UPPER_BYTE_MASK_I,
    input wire logic [15:0] DQ_I,
    input wire logic TEMP_HOT_I,
    output logic [15:0] DQ_O,
    output logic [1:0] DQ_OE_N_O,
    output logic [3:0] BANK_OPEN_O,
    output logic [3:0] BANK_READY_O,
    output sdcmd_pkg::sdcmd_drive_type DRIVE_STRENGTH_O,
    output logic [11:0] MODE_REG_O,
    output logic [3:0] REFRESH_BANKS_O,
    output logic [11:0] REFRESH_ROW_O,
    output logic REFRESH_TICK_O,
    output logic FAST_REFRESH_O,
    output logic SELF_REFRESH_O,
    output logic DEEP_POWER_DOWN_O
);
    import sdcmd_pkg::*;

    localparam int TRP_C = `SDCMD_TRP_CYC;

    generate
        if (TREFI_CYC < 2 || TREFI_CYC > 1023 || TRP_C > 15) begin : g_chk
            $error("Timing count out of range");
        end
    endgenerate

    // ----------------------------------------
    // Burst helpers
    // ----------------------------------------
    function automatic logic [7:0] bl_mask(input logic [2:0] bl);
        logic [7:0] m;
        m = 8'h07;
        if (bl == 3'h0) m = 8'h00;
        else if (bl == 3'h1) m = 8'h01;
        else if (bl == 3'h2) m = 8'h03;
        return m;
    endfunction

    function automatic logic [7:0] beat_col(input logic [7:0] c,
        input logic [2:0] i, input logic [2:0] bl, input logic il);
        logic [7:0] m;
        logic [7:0] o;
        m = bl_mask(bl);
        o = il ? (c ^ {5'h00, i}) : (c + {5'h00, i});
        return (c & ~m) | (o & m);
    endfunction

    sdcmd_state_type s, next_s;
    logic [15:0] mem [0:1023];
    logic [9:0] beat_addr;
    logic beat_we;
    logic [1:0] byte_we;
    logic sel;
    sdcmd_cmd_type cmd;
    logic [3:0] ready;
    logic [1:0] li;
    logic [7:0] lastm;
    logic [10:0] period;

    assign cmd = sdcmd_cmd_type'({CMD_I.ras_n, CMD_I.cas_n, CMD_I.we_n});
    assign sel = !CMD_I.cs_n && s.pwr == PWR_NORMAL;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            ready[b] = !s.open[b] && s.row_precharge_time[b] == 4'h0;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_s = s;
        beat_we = 1'b0;
        beat_addr = 10'h000;
        lastm = 8'h00;
        next_s.rpipe[2] = s.rpipe[1];
        next_s.rpipe[1] = s.rpipe[0];
        next_s.rpipe[0] = 17'h00000;
        next_s.mpipe[1] = s.mpipe[0];
        next_s.mpipe[0] = {UPPER_BYTE_MASK_I, LOWER_BYTE_MASK_I};
        next_s.tick = 1'b0;
        next_s.hot = TEMP_HOT_I;
        for (int b = 0; b < 4; b++) begin
            if (s.row_precharge_time[b] != 4'h0) next_s.row_precharge_time[b] = s.row_precharge_time[b] - 4'h1;
        end
        if (s.pwr != PWR_NORMAL && CMD_I.cke) next_s.pwr = PWR_NORMAL;
        period = s.hot ? TREFI_CYC[10:0] : {TREFI_CYC[9:0], 1'b0};
        if (s.pwr == PWR_SELF && !CMD_I.cke) begin
            next_s.div = s.div + 11'h001;
            if (s.div >= period - 11'h001) begin
                next_s.div = 11'h000;
                next_s.rcnt = s.rcnt + 12'h001;
                next_s.tick = 1'b1;
            end
        end
        if (sel) begin
            unique case (cmd)
                CMD_NOP: begin
                end
                CMD_ACT: begin
                    if (CMD_I.cke && ready[CMD_I.ba]) begin
                        next_s.open[CMD_I.ba] = 1'b1;
                        next_s.row[CMD_I.ba] = CMD_I.addr;
                    end
                end
                CMD_RD, CMD_WR: begin
                    if (CMD_I.cke) begin
                        next_s.bst_act = 1'b1;
                        next_s.bst_rd = cmd == CMD_RD;
                        next_s.bst_ap = CMD_I.addr[`SDCMD_AP_BIT];
                        next_s.bst_bank = CMD_I.ba;
                        next_s.bst_col = CMD_I.addr[7:0];
                        next_s.bst_idx = 3'h0;
                    end
                end
                CMD_BST: begin
                    if (CMD_I.cke) next_s.bst_act = 1'b0;
                    else if (s.open == 4'h0) next_s.pwr = PWR_DEEP;
                end
                CMD_PRE: begin
                    for (int b = 0; b < 4; b++) begin
                        if (CMD_I.cke && s.open[b] &&
                            (CMD_I.addr[`SDCMD_AP_BIT] || CMD_I.ba == b)) begin
                            next_s.open[b] = 1'b0;
                            next_s.row_precharge_time[b] = TRP_C[3:0];
                        end
                    end
                end
                CMD_REF: begin
                    if (CMD_I.cke) begin
                        next_s.rcnt = s.rcnt + 12'h001;
                        next_s.tick = 1'b1;
                    end else begin
                        next_s.pwr = PWR_SELF;
                        next_s.div = 11'h000;
                    end
                end
                CMD_MRS: begin
                    if (CMD_I.cke && CMD_I.ba == `SDCMD_SEL_MODE) begin
                        next_s.mode = CMD_I.addr;
                    end
                    if (CMD_I.cke && CMD_I.ba == `SDCMD_SEL_EXT) begin
                        next_s.partial_array_self_refresh = CMD_I.addr[`SDCMD_EMR_PARTIAL_ARRAY_SELF_REFRESH_HI:0];
                        unique case (CMD_I.addr[`SDCMD_EMR_DS_HI:
                                                `SDCMD_EMR_DS_LO])
                            2'b01: next_s.drv = DRV_HALF;
                            2'b10: next_s.drv = DRV_QUARTER;
                            default: next_s.drv = DRV_FULL;
                        endcase
                    end
                end
            endcase
        end
        // Burst beat
        if (next_s.bst_act) begin
            beat_addr = {next_s.bst_bank, beat_col(next_s.bst_col,
                next_s.bst_idx, next_s.mode[`SDCMD_MR_BL_HI:0],
                next_s.mode[`SDCMD_MR_BT])};
            beat_we = !next_s.bst_rd;
            if (next_s.bst_rd) next_s.rpipe[0] = {1'b1, mem[beat_addr]};
            if (!(beat_we && next_s.mode[`SDCMD_MR_WB])) begin
                lastm = bl_mask(next_s.mode[`SDCMD_MR_BL_HI:0]);
            end
            if (next_s.bst_idx == lastm[2:0]) begin
                next_s.bst_act = 1'b0;
                if (next_s.bst_ap) begin
                    next_s.open[next_s.bst_bank] = 1'b0;
                    next_s.row_precharge_time[next_s.bst_bank] = TRP_C[3:0];
                end
            end else begin
                next_s.bst_idx = next_s.bst_idx + 3'h1;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s <= '0;
            s.mode <= `SDCMD_MODE_RST;
            s.partial_array_self_refresh <= `SDCMD_PARTIAL_ARRAY_SELF_REFRESH_RST;
            s.drv <= DRV_FULL;
            s.pwr <= PWR_NORMAL;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Array
    // ----------------------------------------
    // Masked bytes kept
    assign byte_we = {2{beat_we}} & ~{UPPER_BYTE_MASK_I, LOWER_BYTE_MASK_I};
    always_ff @(posedge CLK_SYS_I) begin
        if (byte_we[0]) mem[beat_addr][7:0] <= DQ_I[7:0];
        if (byte_we[1]) mem[beat_addr][15:8] <= DQ_I[15:8];
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Latency tap
    always_comb begin
        li = 2'h2;
        if (s.mode[`SDCMD_MR_CL_HI:`SDCMD_MR_CL_LO] == 3'h1) li = 2'h0;
        if (s.mode[`SDCMD_MR_CL_HI:`SDCMD_MR_CL_LO] == 3'h2) li = 2'h1;
    end
    assign DQ_O = s.rpipe[li][15:0];
    assign DQ_OE_N_O = ~({2{s.rpipe[li][16]}} & ~s.mpipe[1]);
    assign BANK_OPEN_O = s.open;
    assign BANK_READY_O = ready;
    assign DRIVE_STRENGTH_O = s.drv;
    assign MODE_REG_O = s.mode;
    always_comb begin
        unique case (s.partial_array_self_refresh)
            3'h1: REFRESH_BANKS_O = 4'h3;
            3'h2, 3'h5, 3'h6: REFRESH_BANKS_O = 4'h1;
            default: REFRESH_BANKS_O = 4'hF;
        endcase
    end
    assign REFRESH_ROW_O = s.rcnt;
    assign REFRESH_TICK_O = s.tick;
    assign FAST_REFRESH_O = s.hot;
    assign SELF_REFRESH_O = s.pwr == PWR_SELF;
    assign DEEP_POWER_DOWN_O = s.pwr == PWR_DEEP;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);

    cs_ignore_a: assert property (
        CMD_I.cs_n && !s.bst_act |=> $stable(s.open))
        else $error("Deselected command changed banks");
    act_opens_a: assert property (
        sel && cmd == CMD_ACT && CMD_I.cke && CMD_I.ba == 2'h1 && ready[1]
        |=> s.open[1] && s.row[1] == $past(CMD_I.addr))
        else $error("Activate did not open row");
    pre_all_a: assert property (
        sel && cmd == CMD_PRE && CMD_I.cke && CMD_I.addr[10]
        |=> s.open == 4'h0)
        else $error("Precharge all left a bank open");
    trp_wait_a: assert property (
        sel && cmd == CMD_PRE && CMD_I.cke && CMD_I.ba == 2'h0 && s.open[0]
        |=> !BANK_READY_O[0] ##TRP_C BANK_READY_O[0])
        else $error("Bank ready time wrong");
    ext_load_a: assert property (
        sel && cmd == CMD_MRS && CMD_I.cke && CMD_I.ba == 2'h2
        |=> s.partial_array_self_refresh == $past(CMD_I.addr[2:0]) && $stable(s.mode))
        else $error("Extended load misrouted");
    dpd_keep_a: assert property (
        s.pwr == PWR_DEEP |=> $stable(s.mode) && $stable(s.partial_array_self_refresh)
        && $stable(s.drv))
        else $error("Mode lost in deep power-down");
    self_entry_a: assert property (
        sel && cmd == CMD_REF && !CMD_I.cke |=> SELF_REFRESH_O)
        else $error("Self refresh not entered");
    rd_latency_a: assert property (
        sel && cmd == CMD_RD && CMD_I.cke && s.mode[6:4] == 3'h2
        |=> !(s.rpipe[1][16]) ##1 s.rpipe[li][16])
        else $error("Read latency two wrong");
    rd_mask_a: assert property (
        LOWER_BYTE_MASK_I |-> ##2 DQ_OE_N_O[0])
        else $error("Read mask did not float byte");
    wr_single_a: assert property (
        sel && cmd == CMD_WR && CMD_I.cke && s.mode[9] |=> !s.bst_act)
        else $error("Single write ran a burst");
    ap_close_a: assert property (
        sel && cmd == CMD_RD && CMD_I.cke && CMD_I.addr[10]
        && s.mode[2:0] == 3'h0 && CMD_I.ba == 2'h2 |=> !s.open[2])
        else $error("Auto precharge missed");

    rd_burst_c: cover property (sel && cmd == CMD_RD ##1 s.bst_act [*3]);
    wr_burst_c: cover property (beat_we && UPPER_BYTE_MASK_I);
    self_ref_c: cover property (SELF_REFRESH_O && REFRESH_TICK_O);
    dpd_c: cover property (DEEP_POWER_DOWN_O ##1 !DEEP_POWER_DOWN_O);

endmodule

// *** bench/sdcmd_ctrl_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Memory controller model
// ----------------------------------------
module sdcmd_ctrl_model (
    input wire logic clk_i,
    output sdcmd_pkg::sdcmd_pins_type cmd_o,
    output logic lmask_o,
    output logic umask_o,
    output logic [15:0] dq_o
);
    import sdcmd_pkg::*;

    initial begin
        cmd_o = '1;
        lmask_o = 1'b0;
        umask_o = 1'b0;
        dq_o = 16'h0000;
    end

    task automatic go(input logic [2:0] c, input logic [1:0] b,
        input logic [11:0] a, input logic [15:0] d = 16'h0000,
        input logic cs = 1'b0, input logic [1:0] m = 2'b00);
        cmd_o.cs_n = cs;
        {cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} = c;
        cmd_o.ba = b;
        cmd_o.addr = a;
        dq_o = d;
        {umask_o, lmask_o} = m;
        @(negedge clk_i);
    endtask

    task automatic idle(input int n, input logic [1:0] m = 2'b00);
        repeat (n) begin
            cmd_o.cs_n = 1'b1;
            {cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n, cmd_o.ba, cmd_o.addr} =
                ~{cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n, cmd_o.ba, cmd_o.addr};
            dq_o = ~dq_o;
            {umask_o, lmask_o} = m;
            @(negedge clk_i);
        end
    endtask

    task automatic set_cke(input logic v);
        cmd_o.cke = v;
    endtask
endmodule

// *** bench/sdram_command_decoder_test.sv ***
`timescale 1ns/1ps
module sdram_command_decoder_test;
    import sdcmd_pkg::*;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic hot = 1'b0;
    sdcmd_pins_type cmd;
    logic lm, um, tick, fast, self_r, deep;
    logic [15:0] dqi, dq_o, d, d2;
    logic [1:0] oe_n, b, dv;
    logic [3:0] open_b, ready_b, banks;
    sdcmd_drive_type drv;
    logic [11:0] mode_o, row_o, mode;
    logic [7:0] col;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int tk;

    always #25 clk_sys = ~clk_sys;

    sdcmd_core #(.TREFI_CYC(4)) DUT (.CLK_SYS_I(clk_sys), .RSTN_I(rstn),
        .CMD_I(cmd), .LOWER_BYTE_MASK_I(lm), .UPPER_BYTE_MASK_I(um),
        .DQ_I(dqi), .TEMP_HOT_I(hot), .DQ_O(dq_o), .DQ_OE_N_O(oe_n),
        .BANK_OPEN_O(open_b), .BANK_READY_O(ready_b),
        .DRIVE_STRENGTH_O(drv), .MODE_REG_O(mode_o),
        .REFRESH_BANKS_O(banks), .REFRESH_ROW_O(row_o),
        .REFRESH_TICK_O(tick), .FAST_REFRESH_O(fast),
        .SELF_REFRESH_O(self_r), .DEEP_POWER_DOWN_O(deep));

    sdcmd_ctrl_model ctl (.clk_i(clk_sys), .cmd_o(cmd), .lmask_o(lm),
        .umask_o(um), .dq_o(dqi));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [3:0] eb(input int p);
        case (p)
            1: eb = 4'h3;
            2, 5, 6: eb = 4'h1;
            default: eb = 4'hF;
        endcase
    endfunction

    function automatic logic [15:0] beat_exp(input logic [15:0] w,
        input logic [7:0] c, input int k);
        beat_exp = (k == 0) ? ~w : w ^ 16'((c ^ 8'(k)) & 8'h03);
    endfunction

    task automatic count(input int n);
        tk = 0;
        repeat (n) begin
            tk += int'(tick);
            ctl.idle(1);
        end
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures = failures + 1;
            close_out();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hd47ae339));
        repeat (7) @(negedge clk_sys);
        chk(mode_o, 12'h030);
        chk(oe_n, 2'b11);
        chk(open_b | ready_b, 4'hF);
        @(negedge clk_sys);
        rstn = 1'b1;
        ctl.idle(3);
        for (int i = 0; i < 4; i++) begin
            ctl.go(CMD_ACT, 2'(i), 12'($urandom));
        end
        chk(open_b, 4'hF);
        b = 2'($urandom);
        ctl.go(CMD_PRE, b, 12'(10'($urandom)));
        chk(open_b, 4'(~(4'b0001 << b)));
        chk(ready_b[b], 1'b0);
        ctl.idle(1);
        chk(ready_b[b], 1'b1);
        ctl.go(CMD_PRE, ~b, {2'b01, 10'($urandom)});
        chk(open_b, 4'h0);
        ctl.idle(1);
        ctl.go(CMD_ACT, b, 12'($urandom), 16'($urandom), 1'b1);
        chk(open_b, 4'h0);
        ctl.go(CMD_REF, 2'($urandom), 12'($urandom));
        ctl.go(CMD_REF, 2'($urandom), 12'($urandom));
        chk(row_o, 12'h002);
        for (int p = 0; p < 8; p++) begin
            dv = 2'(p % 3);
            ctl.go(CMD_MRS, 2'b10, {5'h00, dv, 2'($urandom), 3'(p)});
            ctl.idle(2);
            chk(banks, eb(p));
            chk(drv, dv);
            chk(mode_o, 12'h030);
        end
        for (int m = 1; m < 4; m++) begin
            mode = 12'(m << 4);
            ctl.go(CMD_MRS, 2'b00, mode);
            ctl.idle(2);
            chk(mode_o, mode);
            b = 2'($urandom);
            col = 8'($urandom);
            d = 16'($urandom);
            d2 = 16'($urandom);
            ctl.go(CMD_ACT, b, 12'($urandom));
            chk(open_b, 4'b0001 << b);
            ctl.go(CMD_WR, b, {4'h0, col}, d);
            ctl.go(CMD_WR, b, {4'h0, col}, d2, 1'b0, 2'b01);
            ctl.idle(1);
            ctl.go(CMD_RD, b, {1'b0, m == 3, 2'b00, col});
            for (int k = 1; k < m; k++) begin
                chk(oe_n, 2'b11);
                ctl.idle(1, {m == 3 && k == 1, 1'b0});
            end
            chk(oe_n, m == 3 ? 2'b10 : 2'b00);
            chk(dq_o[7:0], d[7:0]);
            if (m < 3) chk(dq_o[15:8], d2[15:8]);
            ctl.idle(2);
            if (m < 3) ctl.go(CMD_PRE, b, 12'(10'($urandom)));
            chk(open_b, 4'h0);
            ctl.idle(2);
        end
        // Aligned burst write, single write, interleaved read, stop
        b = 2'($urandom);
        col = 8'($urandom);
        d = 16'($urandom);
        ctl.go(CMD_MRS, 2'b00, 12'h02A);
        ctl.idle(2);
        ctl.go(CMD_ACT, b, 12'($urandom));
        for (int k = 0; k < 4; k++) begin
            ctl.go(k == 0 ? CMD_WR : CMD_NOP, b, {4'h0, col & 8'hFC},
                d ^ 16'(k));
        end
        ctl.go(CMD_PRE, b, 12'(10'($urandom)));
        ctl.idle(1);
        ctl.go(CMD_MRS, 2'b00, 12'h22A);
        ctl.idle(2);
        chk(mode_o, 12'h22A);
        ctl.go(CMD_ACT, b, 12'($urandom));
        ctl.go(CMD_WR, b, {4'h0, col}, ~d);
        ctl.go(CMD_NOP, b, {4'h0, col}, 16'($urandom));
        ctl.go(CMD_RD, b, {4'h4, col});
        ctl.idle(1);
        for (int k = 0; k < 4; k++) begin
            chk(dq_o, beat_exp(d, col, k));
            chk(oe_n, 2'b00);
            ctl.idle(1);
        end
        chk(open_b, 4'h0);
        ctl.go(CMD_ACT, b, 12'($urandom));
        ctl.go(CMD_RD, b, {4'h0, col});
        ctl.go(CMD_BST, 2'($urandom), 12'($urandom));
        chk(oe_n, 2'b00);
        ctl.idle(1);
        chk(oe_n, 2'b11);
        chk(open_b, 4'b0001 << b);
        ctl.go(CMD_PRE, b, 12'(10'($urandom)));
        ctl.idle(1);
        ctl.set_cke(1'b0);
        ctl.go(CMD_REF, 2'($urandom), 12'($urandom));
        chk(self_r, 1'b1);
        hot = 1'b1;
        ctl.idle(4);
        chk(fast, 1'b1);
        count(16);
        chk(16'(tk), 16'h0004);
        hot = 1'b0;
        ctl.idle(8);
        count(32);
        chk(16'(tk), 16'h0004);
        ctl.set_cke(1'b1);
        ctl.idle(2);
        chk(self_r, 1'b0);
        ctl.set_cke(1'b0);
        ctl.go(CMD_BST, 2'($urandom), 12'($urandom));
        chk(deep, 1'b1);
        ctl.go(CMD_MRS, 2'($urandom), 12'($urandom));
        ctl.set_cke(1'b1);
        ctl.idle(2);
        chk(deep, 1'b0);
        chk(mode_o, 12'h22A);
        chk(drv, DRV_HALF);
        rstn = 1'b0;
        ctl.idle(1);
        chk(drv, DRV_FULL);
        chk(mode_o, 12'h030);
        rstn = 1'b1;
        ctl.idle(2);
        chk(open_b | ready_b, 4'hF);
        close_out();
    end
endmodule
